// File: verilog/channel_trim_and_slot_registers.sv
// Per-input alert deadband, offset and gain trims and sequence slot table
//
// The Wishbone interface to the registers was left to the implementer.
`timescale 1ns/1ps
`include "trim_consts.svh"

// Notes on behaviour
// [RULE_01] Each of 16 inputs has a 12-bit read-write deadband, reset 0x10.
// [RULE_02] Deadband uses the scale of the 12 top bits of a result.
// [RULE_03] Deadband of input n sits at index 0x80 + 2n, last at 0x9E.
// [RULE_04] 16-bit offset trim per input, reset zero, given to each result.
// [RULE_05] Offset trim of input n sits at index 0xA0 + 2n, last 0xBE.
// [RULE_06] 16-bit gain trim per input, reset 0x8000, given to each result.
// [RULE_07] Gain trim of input n sits at index 0xC0 + 2n, last 0xDE.
// [RULE_08] Each slot holds a 4-bit input code in bits 3..0, reset zero.
// [RULE_09] 128 byte-wide slots at index 0x100 + n, up to 0x17F.
// [RULE_10] Reserved high bits of deadband and slot read zero, ignore writes.
module channel_trim_and_slot_registers
(
   input  wire logic                 clk_i,
   input  wire logic                 rst_i,
   input  wire trim_pkg::wb_req_t    wb_i,
   output trim_pkg::wb_rsp_t         wb_o,
   output trim_pkg::trim_cfg_t       cfg_o,
   input  wire logic [3:0]           result_chan_i,
   output trim_pkg::chan_trim_t      trim_o
);

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------

   // Map a register index onto a region and an entry number
   function automatic trim_pkg::hit_t decode(input logic [8:0] idx);
      trim_pkg::hit_t h;
      h.kind = trim_pkg::REG_NONE;
      h.ch   = 7'h00;
      if (idx >= `DB_BASE && idx <= `DB_LAST && !idx[0])
      begin
         h.kind = trim_pkg::REG_DB;
         h.ch   = 7'((idx - `DB_BASE) >> 1);
      end
      else if (idx >= `OFS_BASE && idx <= `OFS_LAST && !idx[0])
      begin
         h.kind = trim_pkg::REG_OFS;
         h.ch   = 7'((idx - `OFS_BASE) >> 1);
      end
      else if (idx >= `GAIN_BASE && idx <= `GAIN_LAST && !idx[0])
      begin
         h.kind = trim_pkg::REG_GAIN;
         h.ch   = 7'((idx - `GAIN_BASE) >> 1);
      end
      else if (idx >= `SLOT_BASE && idx <= `SLOT_LAST)
      begin
         h.kind = trim_pkg::REG_SLOT;
         h.ch   = 7'(idx - `SLOT_BASE);
      end
      return h;
   endfunction

   // Merge a 16-bit write into an old value, lane by lane
   function automatic logic [15:0] merge16(input logic [15:0] old_v,
                                           input logic [15:0] new_v,
                                           input logic [1:0]  sel);
      logic [15:0] r;
      r = old_v;
      if (sel[0])
      begin
         r[7:0] = new_v[7:0];
      end
      if (sel[1])
      begin
         r[15:8] = new_v[15:8];
      end
      return r;
   endfunction

   // ---------------------------------------------------------------
   // Storage
   // ---------------------------------------------------------------

   logic [15:0][11:0] deadband;
   logic [15:0][15:0] offset;
   logic [15:0][15:0] gain;
   logic [127:0][3:0] slot;
   logic              ack;
   logic [31:0]       rdata;

   // ---------------------------------------------------------------
   // Bus decode
   // ---------------------------------------------------------------

   logic [8:0]     idx;
   logic [3:0]     chan;
   logic           req;
   logic           wr_now;
   logic           in_range;
   trim_pkg::hit_t hit;
   logic [31:0]    next_rdata;

   // Index is the word address; upper address bits must be clear
   assign idx      = wb_i.adr[10:2];
   assign in_range = (wb_i.adr[31:11] == `ADR_HI_W'h0);
   assign req      = wb_i.cyc & wb_i.stb;
   assign hit      = in_range ? decode(idx)
                              : trim_pkg::hit_t'{trim_pkg::REG_NONE, 7'h00};
   // Trim and deadband regions hold 16 entries, so 4 bits pick one
   assign chan     = hit.ch[3:0];
   // Writes land on the edge where the master sees ack
   assign wr_now   = req & wb_i.we & ack;

   // Read mux; unmapped indices and odd deadband, offset and gain indices read zero
   always_comb
   begin
      next_rdata = 32'h0;
      unique case (hit.kind)
         trim_pkg::REG_NONE: next_rdata = 32'h0;
         trim_pkg::REG_DB:   next_rdata = {20'h0, deadband[chan]}; // RULE_03
         trim_pkg::REG_OFS:  next_rdata = {16'h0, offset[chan]};   // RULE_05
         trim_pkg::REG_GAIN: next_rdata = {16'h0, gain[chan]};     // RULE_07
         trim_pkg::REG_SLOT: next_rdata = {28'h0, slot[hit.ch]};          // RULE_09
      endcase
   end

   // ---------------------------------------------------------------
   // Wishbone answer
   // ---------------------------------------------------------------

   // One wait state; ack drops in the cycle after it was given
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ack <= 1'b0;
      end
      else
      begin
         ack <= req & ~ack;
      end
   end

   // Read data is caught together with the rise of ack
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         rdata <= 32'h0;
      end
      else if (req & ~ack)
      begin
         rdata <= next_rdata;
      end
   end

   assign wb_o = '{dat: rdata, ack: ack};

   // ---------------------------------------------------------------
   // Register writes
   // ---------------------------------------------------------------

   // Deadband: only bits 11..0 are stored, so the top nibble stays zero
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         for (int i = 0; i < 16; i++)
         begin
            deadband[i] <= `DB_RESET; // RULE_01
         end
      end
      else if (wr_now && hit.kind == trim_pkg::REG_DB)
      begin
         deadband[hit.ch[3:0]] <= 12'(merge16({4'h0, deadband[hit.ch[3:0]]},
                                             wb_i.dat[15:0],
                                             wb_i.sel[1:0])); // RULE_10
      end
   end

   // Offset trims
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         for (int i = 0; i < 16; i++)
         begin
            offset[i] <= `OFS_RESET; // RULE_04
         end
      end
      else if (wr_now && hit.kind == trim_pkg::REG_OFS)
      begin
         offset[hit.ch[3:0]] <= merge16(offset[hit.ch[3:0]],
                                        wb_i.dat[15:0], wb_i.sel[1:0]);
      end
   end

   // Gain trims; the reset value is unity gain
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         for (int i = 0; i < 16; i++)
         begin
            gain[i] <= `GAIN_RESET; // RULE_06
         end
      end
      else if (wr_now && hit.kind == trim_pkg::REG_GAIN)
      begin
         gain[hit.ch[3:0]] <= merge16(gain[hit.ch[3:0]],
                                      wb_i.dat[15:0], wb_i.sel[1:0]);
      end
   end

   // Slot table: only the low nibble of lane 0 is kept
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         for (int i = 0; i < 128; i++)
         begin
            slot[i] <= `SLOT_RESET;
         end
      end
      else if (wr_now && hit.kind == trim_pkg::REG_SLOT && wb_i.sel[0])
      begin
         slot[hit.ch] <= wb_i.dat[3:0]; // RULE_08
      end
   end

   assign cfg_o = '{deadband: deadband, offset: offset,
                    gain: gain, slot: slot};

   // ---------------------------------------------------------------
   // Per-result trim lookup
   // ---------------------------------------------------------------

   // Registered so the correction path sees a clean flop; costs one cycle
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         trim_o <= '{offset: `OFS_RESET, gain: `GAIN_RESET,
                     deadband: {`DB_RESET, 4'h0}};
      end
      else
      begin
         trim_o.offset   <= offset[result_chan_i];   // RULE_04
         trim_o.gain     <= gain[result_chan_i];     // RULE_06
         // Deadband sits on the top 12 bits of the 16-bit result scale
         trim_o.deadband <= {deadband[result_chan_i], 4'h0}; // RULE_02
      end
   end

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   property p_db_write;
      wr_now && hit.kind == trim_pkg::REG_DB && wb_i.sel[1:0] == 2'b11
      |=> deadband[$past(hit.ch[3:0])] == $past(wb_i.dat[11:0]);
   endproperty
   a_db_write: assert property (p_db_write) // RULE_01
      else $error("deadband write not stored");

   property p_db_scale;
      ##1 trim_o.deadband == {$past(deadband[result_chan_i]), 4'h0};
   endproperty
   a_db_scale: assert property (p_db_scale) // RULE_02
      else $error("deadband not on result scale");

   property p_db_last;
      req && !ack && in_range && idx == `DB_LAST
      |=> wb_o.ack && wb_o.dat == {20'h0, $past(deadband[15])};
   endproperty
   a_db_last: assert property (p_db_last) // RULE_03
      else $error("last deadband index misread");

   property p_ofs_apply;
      ##1 trim_o.offset == $past(offset[result_chan_i]);
   endproperty
   a_ofs_apply: assert property (p_ofs_apply) // RULE_04
      else $error("offset trim not given to result");

   property p_ofs_first;
      req && !ack && in_range && idx == `OFS_BASE
      |=> wb_o.dat == {16'h0, $past(offset[0])};
   endproperty
   a_ofs_first: assert property (p_ofs_first) // RULE_05
      else $error("first offset index misread");

   property p_gain_apply;
      ##1 trim_o.gain == $past(gain[result_chan_i]);
   endproperty
   a_gain_apply: assert property (p_gain_apply) // RULE_06
      else $error("gain trim not given to result");

   property p_gain_last;
      req && !ack && in_range && idx == `GAIN_LAST
      |=> wb_o.dat == {16'h0, $past(gain[15])};
   endproperty
   a_gain_last: assert property (p_gain_last) // RULE_07
      else $error("last gain index misread");

   property p_slot_write;
      wr_now && hit.kind == trim_pkg::REG_SLOT && wb_i.sel[0]
      |=> slot[$past(hit.ch)] == $past(wb_i.dat[3:0]);
   endproperty
   a_slot_write: assert property (p_slot_write) // RULE_08
      else $error("slot write not stored");

   property p_slot_last;
      req && !ack && in_range && idx == `SLOT_LAST
      |=> wb_o.dat == {28'h0, $past(slot[127])};
   endproperty
   a_slot_last: assert property (p_slot_last) // RULE_09
      else $error("last slot index misread");

   property p_reserved_zero;
      wb_o.ack && $past(hit.kind) == trim_pkg::REG_SLOT
      |-> wb_o.dat[31:4] == 28'h0;
   endproperty
   a_reserved_zero: assert property (p_reserved_zero) // RULE_10
      else $error("reserved slot bits not zero");

endmodule

// File: verilog/trim_consts.svh
// Register indices, reset values and field limits of the trim bank
`ifndef TRIM_CONSTS_SVH
`define TRIM_CONSTS_SVH

// Register indices; the byte address on the bus is four times the index
`define DB_BASE    9'h080
`define DB_LAST    9'h09e
`define OFS_BASE   9'h0a0
`define OFS_LAST   9'h0be
`define GAIN_BASE  9'h0c0
`define GAIN_LAST  9'h0de
`define SLOT_BASE  9'h100
`define SLOT_LAST  9'h17f

// Reset values
`define DB_RESET   12'h010
`define OFS_RESET  16'h0000
`define GAIN_RESET 16'h8000
`define SLOT_RESET 4'h0

// Width of the address bits above the decoded index that must be zero
`define ADR_HI_W   21

`endif

// File: verilog/trim_pkg.sv
// Types shared by the trim and slot register bank
package trim_pkg;

   // Classic Wishbone request from the master
   typedef struct packed {
      logic [31:0] adr;
      logic [31:0] dat;
      logic [3:0]  sel;
      logic        we;
      logic        cyc;
      logic        stb;
   } wb_req_t;

   // Wishbone answer from this slave
   typedef struct packed {
      logic [31:0] dat;
      logic        ack;
   } wb_rsp_t;

   // Register region picked by the address decoder
   typedef enum logic [2:0] {
      REG_NONE,
      REG_DB,
      REG_OFS,
      REG_GAIN,
      REG_SLOT
   } region_t;

   // Decoder result: region and entry number inside it
   typedef struct packed {
      region_t    kind;
      logic [6:0] ch;
   } hit_t;

   // Whole configuration, as consumed by the alert, trim and sequencer logic
   typedef struct packed {
      logic [15:0][11:0] deadband;
      logic [15:0][15:0] offset;
      logic [15:0][15:0] gain;
      logic [127:0][3:0] slot;
   } trim_cfg_t;

   // Trim values for the input of the result being processed
   typedef struct packed {
      logic [15:0] offset;
      logic [15:0] gain;
      logic [15:0] deadband;
   } chan_trim_t;

endpackage

// File: testbench/tb_top.sv
// Self-checking bench for the trim and sequence slot register bank
`timescale 1ns/1ps

module tb_top;

   // ------------------------------------------------------------
   // Signals and reference model
   // ------------------------------------------------------------
   logic                 clk_i;
   logic                 rst_i;
   trim_pkg::wb_req_t    wb_i;
   trim_pkg::wb_rsp_t    wb_o;
   trim_pkg::trim_cfg_t  cfg_o;
   logic [3:0]           result_chan_i;
   trim_pkg::chan_trim_t trim_o;
   int                   bad_count;
   int                   tests_run;
   logic [31:0]          seed;
   logic [11:0]          db [16];
   logic [15:0]          ofs [16];
   logic [15:0]          gn [16];
   logic [3:0]           sl [128];
   logic [31:0]          odd_adr [6];

   channel_trim_and_slot_registers channel_trim_and_slot_registers_inst
   (
      .clk_i         (clk_i),
      .rst_i         (rst_i),
      .wb_i          (wb_i),
      .wb_o          (wb_o),
      .cfg_o         (cfg_o),
      .result_chan_i (result_chan_i),
      .trim_o        (trim_o)
   );

   // 100 ns clock
   initial
   begin
      clk_i = 1'b0;
      forever #50 clk_i = ~clk_i;
   end

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   // Xorshift keeps the random stream repeatable across runs
   function logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   // Byte address of a register index
   function logic [31:0] badr(input int idx);
      return idx * 4;
   endfunction

   // Byte-lane merge of a write into a stored halfword
   function logic [15:0] mrg(input logic [15:0] o, input logic [15:0] n,
                             input logic [3:0] s);
      return {s[1] ? n[15:8] : o[15:8], s[0] ? n[7:0] : o[7:0]};
   endfunction

   task automatic complete_run();
      if (bad_count == 0 && tests_run > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("BAD %0t got %h want %h", $time, seen, exp);
      end
   endtask

   // One classic cycle; request held until ack is sampled high
   task automatic bus(input logic [31:0] a, input logic [31:0] d,
                      input logic w, input logic [3:0] s,
                      output logic [31:0] q);
      int i;
      @(posedge clk_i);
      wb_i.cyc <= 1'b1;
      wb_i.stb <= 1'b1;
      wb_i.adr <= a;
      wb_i.dat <= d;
      wb_i.we  <= w;
      wb_i.sel <= s;
      for (i = 0; i < 20; i++)
      begin
         @(posedge clk_i);
         if (wb_o.ack === 1'b1)
            break;
      end
      if (i == 20)
      begin
         bad_count++;
         complete_run();
      end
      q = wb_o.dat;
      wb_i.cyc <= 1'b0;
      wb_i.stb <= 1'b0;
      wb_i.we  <= 1'b0;
   endtask

   // Reset and load the model with reset values
   task automatic do_reset();
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      for (int n = 0; n < 16; n++)
      begin
         db[n]  = 12'h010;
         ofs[n] = 16'h0000;
         gn[n]  = 16'h8000;
      end
      for (int n = 0; n < 128; n++)
         sl[n] = 4'h0;
   endtask

   // Read back every register and compare the stored view too
   task automatic check_all();
      logic [31:0] q;
      for (int n = 0; n < 16; n++)
      begin
         bus(badr('h80 + 2 * n), 32'h0, 1'b0, 4'hf, q);
         chk(q, {20'h0, db[n]});
         bus(badr('ha0 + 2 * n), 32'h0, 1'b0, 4'hf, q);
         chk(q, {16'h0, ofs[n]});
         bus(badr('hc0 + 2 * n), 32'h0, 1'b0, 4'hf, q);
         chk(q, {16'h0, gn[n]});
         chk(cfg_o.deadband[n], db[n]);
         chk(cfg_o.offset[n], ofs[n]);
         chk(cfg_o.gain[n], gn[n]);
      end
      for (int n = 0; n < 128; n++)
      begin
         bus(badr('h100 + n), 32'h0, 1'b0, 4'hf, q);
         chk(q, {28'h0, sl[n]});
         chk(cfg_o.slot[n], sl[n]);
      end
   endtask

   // Per-input trim lookup, one cycle of latency
   task automatic check_trim();
      for (int k = 0; k < 16; k++)
      begin
         @(posedge clk_i);
         result_chan_i <= 4'(k);
         repeat (2) @(posedge clk_i);
         chk(trim_o, {ofs[k], gn[k], db[k], 4'h0});
      end
   endtask

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial
   begin
      logic [31:0] d;
      logic [31:0] s;
      logic [31:0] q;
      logic [15:0] t;
      wb_i = '0;
      result_chan_i = 4'h0;
      bad_count = 0;
      tests_run = 0;
      seed = 32'd23114;
      odd_adr = '{badr('h81), badr('h9f), badr('he0), badr('h180),
                  32'h800 | badr('h80), badr('h7e)};
      do_reset();
      check_all();
      check_trim();
      // Random data and byte enables, sel of zero included by chance
      for (int r = 0; r < 2; r++)
      begin
         for (int n = 0; n < 16; n++)
         begin
            d = rnd();
            s = rnd();
            bus(badr('h80 + 2 * n), d, 1'b1, s[3:0], q);
            t = mrg({4'h0, db[n]}, d[15:0], s[3:0]);
            db[n] = t[11:0];
            d = rnd();
            bus(badr('ha0 + 2 * n), d, 1'b1, s[7:4], q);
            ofs[n] = mrg(ofs[n], d[15:0], s[7:4]);
            d = rnd();
            bus(badr('hc0 + 2 * n), d, 1'b1, s[11:8], q);
            gn[n] = mrg(gn[n], d[15:0], s[11:8]);
         end
         // First pass walks every input code through the slots
         for (int n = 0; n < 128; n++)
         begin
            d = (r == 0) ? n : rnd();
            s = (r == 0) ? 32'hf : rnd();
            bus(badr('h100 + n), d, 1'b1, s[3:0], q);
            if (s[0])
               sl[n] = d[3:0];
         end
      end
      // Reserved bits of the last entries stay zero
      bus(badr('h9e), 32'hffffffff, 1'b1, 4'hf, q);
      db[15] = 12'hfff;
      bus(badr('h17f), 32'hffffffff, 1'b1, 4'hf, q);
      sl[127] = 4'hf;
      // Holes and aliases answer zero and keep the bank untouched
      for (int i = 0; i < 6; i++)
      begin
         bus(odd_adr[i], 32'hffffffff, 1'b1, 4'hf, q);
         bus(odd_adr[i], 32'h0, 1'b0, 4'hf, q);
         chk(q, 48'h0);
      end
      check_all();
      check_trim();
      // Reset in mid-run brings every default back
      do_reset();
      check_all();
      check_trim();
      complete_run();
   end

endmodule
